/* File: core/stwcs_slave.sv */
// Two-wire command slave: address match, command decode, register file
//
// How it works
// - With write-control clear, every completed register write starts a store.
// - With write-control set, only the commit command 3Fh or a device-select write starts a store.
// - Writing device-select always starts a store of all writable registers.
// - During a store (up to 10 ms) every address is refused; master retries.
// - Command 37h reads the range value, high eight bits, then bits 5 to 1 left-justified.
// - Command 08h: DAC as eight MSBs then two LSBs in top bits.
// - Command 0Eh: offset byte, low five bits used, top three read as one.
// - Command 01h: divider as eight MSBs then two LSBs left-justified.
// - Command 02h: mux word as eight MSBs then two LSBs left-justified.
// - Command 0Dh: device-select, low five bits used, top three read zero.
// - Read: command written first, repeated START, address with direction 1.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - SDA changes only while SCL is low; one bit per SCL pulse.
// - Receiver holds SDA low through the ninth clock to acknowledge.
// - Master leaves last read byte unacked; device then releases SDA.
// - Works at both standard and fast bus clock rates.
// - Repeated START ends one transfer and begins the next.
// - Three device-select bits, reset to 000, set the bus address.
// - Address byte is type code, three select bits, then direction.
// - After new select bits are written, only the new address answers.
`timescale 1ns/10ps

module stwcs_slave #(
  // Arbitrary device-type code for the upper address nibble
  parameter logic [3:0] DEVICE_TYPE = 4'h5,
  parameter logic [9:0] DAC_RESET = 10'h200,
  parameter logic [4:0] OFFSET_RESET = 5'h00,
  // Store busy window, shorten in simulation
  parameter int unsigned STORE_CYCLES = stwcs_pkg::STORE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Two-wire bus (SCL is also the link clock)
  input wire logic link_scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Factory range value
  input wire logic [13:0] range_value,
  // Register contents toward the synthesiser
  output logic [9:0] divider_word,
  output logic [9:0] output_mux_word,
  output logic [9:0] frequency_dac_word,
  output logic [4:0] frequency_offset,
  output logic [4:0] device_select_control,
  // Nonvolatile store control
  output logic eeprom_store_start,
  output logic eeprom_busy
);

  localparam int SCW = $clog2(STORE_CYCLES + 1);
  localparam logic [SCW-1:0] STORE_LAST = SCW'(STORE_CYCLES - 1);

  // ---------------------------------------------------------------
  // Link domain: sample SDA on every rising SCL
  // ---------------------------------------------------------------
  logic link_bit;
  logic link_tog;

  // One bit per SCL pulse; the toggle marks it for the other domain
  always_ff @(posedge link_scl or negedge rstn) begin
    if (!rstn) begin
      link_bit <= 1'b1;
      link_tog <= 1'b0;
    end else begin
      link_bit <= sda_in;
      link_tog <= ~link_tog;
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers and bus conditions
  // ---------------------------------------------------------------
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] tog_sync;
  logic scl_q;
  logic sda_q;
  logic tog_q;

  // Three stages; a level only counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      tog_sync <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[1:0], link_scl};
      sda_sync <= {sda_sync[1:0], sda_in};
      tog_sync <= {tog_sync[1:0], link_tog};
    end
  end

  wire next_scl = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
  wire next_sda = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
  wire next_tog = (tog_sync[1] == tog_sync[2]) ? tog_sync[2] : tog_q;

  // Filtered line levels
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      tog_q <= 1'b0;
    end else begin
      scl_q <= next_scl;
      sda_q <= next_sda;
      tog_q <= next_tog;
    end
  end

  // SDA moving while SCL stays high is a bus condition, not data
  wire start_evt = scl_q && next_scl && sda_q && !next_sda;
  wire stop_evt = scl_q && next_scl && !sda_q && next_sda;
  wire scl_fall = scl_q && !next_scl;
  // link_bit is stable for a whole SCL period after its toggle lands
  wire bit_evt = next_tog != tog_q;

  // ---------------------------------------------------------------
  // Bit counter and receive shifter
  // ---------------------------------------------------------------
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;

  // Nine clocks per byte: eight data, one acknowledge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
    end else begin
      if (start_evt)
        bit_cnt <= 4'h0;
      else if (bit_evt)
        bit_cnt <= (bit_cnt == stwcs_pkg::BYTE_BITS) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_evt)
        rx_shift <= {rx_shift[6:0], link_bit};
    end
  end

  wire byte_end = scl_fall && (bit_cnt == stwcs_pkg::BYTE_BITS);
  wire ack_done = scl_fall && (bit_cnt == 4'h0);

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  stwcs_pkg::stwcs_state_type state;
  logic rd_mode;
  logic [7:0] tx_byte;
  logic [7:0] rd_data;

  // Upper nibble fixed, then the live select bits
  wire addr_hit = rx_shift[7:1] == {DEVICE_TYPE, device_select_control[2:0]};
  wire addr_take = (state == stwcs_pkg::ST_ADDR) && byte_end &&
                   addr_hit && !eeprom_busy;
  wire tx_load = ((state == stwcs_pkg::ST_ACK) && ack_done && rd_mode) ||
                 ((state == stwcs_pkg::ST_TXACK) && ack_done);
  wire [2:0] tx_pos = 3'(4'h7 - bit_cnt);

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // Drive decisions are taken on falling SCL so SDA settles while low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= stwcs_pkg::ST_IDLE;
      sda_oe <= 1'b0;
      rd_mode <= 1'b0;
      tx_byte <= 8'h00;
    end else if (start_evt) begin
      state <= stwcs_pkg::ST_ADDR;
      sda_oe <= 1'b0;
    end else if (stop_evt) begin
      state <= stwcs_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        stwcs_pkg::ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        stwcs_pkg::ST_ADDR: begin
          if (addr_take) begin
            state <= stwcs_pkg::ST_ACK;
            sda_oe <= 1'b1;
            rd_mode <= rx_shift[0];
          end else if (byte_end) begin
            state <= stwcs_pkg::ST_IDLE;
          end
        end
        stwcs_pkg::ST_RX: begin
          if (byte_end) begin
            state <= stwcs_pkg::ST_ACK;
            sda_oe <= 1'b1;
          end
        end
        stwcs_pkg::ST_ACK: begin
          if (ack_done && rd_mode) begin
            state <= stwcs_pkg::ST_TX;
            tx_byte <= rd_data;
            sda_oe <= ~rd_data[7];
          end else if (ack_done) begin
            state <= stwcs_pkg::ST_RX;
            sda_oe <= 1'b0;
          end
        end
        stwcs_pkg::ST_TX: begin
          if (byte_end) begin
            state <= stwcs_pkg::ST_TXACK;
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            sda_oe <= ~tx_byte[tx_pos];
          end
        end
        stwcs_pkg::ST_TXACK: begin
          if (bit_evt && link_bit) begin
            state <= stwcs_pkg::ST_IDLE;
          end else if (ack_done) begin
            state <= stwcs_pkg::ST_TX;
            tx_byte <= rd_data;
            sda_oe <= ~rd_data[7];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command decode and register file
  // ---------------------------------------------------------------
  logic [7:0] cmd;
  logic have_cmd;
  logic [1:0] byte_idx;
  logic wrote_pend;
  logic commit_pend;
  logic select_pend;

  wire rx_done = (state == stwcs_pkg::ST_RX) && byte_end;
  wire cmd_take = rx_done && !have_cmd;
  wire wr_en = rx_done && have_cmd;
  wire wr_hi = wr_en && (byte_idx == 2'h0);
  wire wr_lo = wr_en && (byte_idx == 2'h1);
  wire wr_known = (cmd == stwcs_pkg::CMD_DIVIDER) ||
                  (cmd == stwcs_pkg::CMD_MUX) ||
                  (cmd == stwcs_pkg::CMD_DAC) ||
                  (cmd == stwcs_pkg::CMD_OFFSET) ||
                  (cmd == stwcs_pkg::CMD_SELECT);
  wire wc_set = device_select_control[stwcs_pkg::SEL_WC_BIT];

  // Read byte for the selected register and byte position
  function automatic logic [7:0] stwcs_read_byte(
    input logic [7:0] code,
    input logic [1:0] idx,
    input logic [9:0] div_v,
    input logic [9:0] mux_v,
    input logic [9:0] dac_v,
    input logic [4:0] ofs_v,
    input logic [4:0] sel_v,
    input logic [13:0] rng_v
  );
    logic [9:0] word;
    word = 10'h000;
    stwcs_read_byte = 8'h00;
    if (code == stwcs_pkg::CMD_DIVIDER)
      word = div_v;
    else if (code == stwcs_pkg::CMD_MUX)
      word = mux_v;
    else if (code == stwcs_pkg::CMD_DAC)
      word = dac_v;
    if (code == stwcs_pkg::CMD_OFFSET) begin
      if (idx == 2'h0)
        stwcs_read_byte = {stwcs_pkg::OFFSET_PAD, ofs_v};
    end else if (code == stwcs_pkg::CMD_SELECT) begin
      if (idx == 2'h0)
        stwcs_read_byte = {3'h0, sel_v};
    end else if (code == stwcs_pkg::CMD_RANGE) begin
      if (idx == 2'h0)
        stwcs_read_byte = rng_v[13:6];
      else if (idx == 2'h1)
        stwcs_read_byte = {rng_v[5:1], 3'h0};
    end else if (idx == 2'h0) begin
      stwcs_read_byte = word[9:2];
    end else if (idx == 2'h1) begin
      stwcs_read_byte = {word[1:0], 6'h00};
    end
  endfunction : stwcs_read_byte

  assign rd_data = stwcs_read_byte(cmd, byte_idx, divider_word,
                                   output_mux_word, frequency_dac_word,
                                   frequency_offset, device_select_control,
                                   range_value);

  // Command byte, then a byte pointer that saturates past the last byte
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= 8'h00;
      have_cmd <= 1'b0;
      byte_idx <= 2'h0;
    end else if (start_evt) begin
      have_cmd <= 1'b0;
      byte_idx <= 2'h0;
    end else if (cmd_take) begin
      cmd <= rx_shift;
      have_cmd <= 1'b1;
      byte_idx <= 2'h0;
    end else if ((wr_en || tx_load) && byte_idx != stwcs_pkg::LAST_INDEX) begin
      byte_idx <= byte_idx + 2'h1;
    end
  end

  // Two-byte words take the high byte first, low bits from the top
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divider_word <= stwcs_pkg::DIVIDER_RESET;
      output_mux_word <= stwcs_pkg::MUX_RESET;
      frequency_dac_word <= DAC_RESET;
      frequency_offset <= OFFSET_RESET;
      device_select_control <= stwcs_pkg::SELECT_RESET;
    end else begin
      if (wr_hi && cmd == stwcs_pkg::CMD_DIVIDER)
        divider_word[9:2] <= rx_shift;
      if (wr_lo && cmd == stwcs_pkg::CMD_DIVIDER)
        divider_word[1:0] <= rx_shift[7:6];
      if (wr_hi && cmd == stwcs_pkg::CMD_MUX)
        output_mux_word[9:2] <= rx_shift;
      if (wr_lo && cmd == stwcs_pkg::CMD_MUX)
        output_mux_word[1:0] <= rx_shift[7:6];
      if (wr_hi && cmd == stwcs_pkg::CMD_DAC)
        frequency_dac_word[9:2] <= rx_shift;
      if (wr_lo && cmd == stwcs_pkg::CMD_DAC)
        frequency_dac_word[1:0] <= rx_shift[7:6];
      if (wr_hi && cmd == stwcs_pkg::CMD_OFFSET)
        frequency_offset <= rx_shift[4:0];
      // New select bits are matched from the next address on
      if (wr_hi && cmd == stwcs_pkg::CMD_SELECT)
        device_select_control <= rx_shift[4:0];
    end
  end

  // ---------------------------------------------------------------
  // Nonvolatile store sequencing
  // ---------------------------------------------------------------
  logic [SCW-1:0] store_cnt;
  wire frame_end = start_evt || stop_evt;
  wire store_req = frame_end &&
                   (select_pend || commit_pend || (wrote_pend && !wc_set));

  // Pending flags: a write only counts as complete at STOP or re-START
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrote_pend <= 1'b0;
      commit_pend <= 1'b0;
      select_pend <= 1'b0;
    end else begin
      if (frame_end) begin
        wrote_pend <= 1'b0;
        commit_pend <= 1'b0;
        select_pend <= 1'b0;
      end
      // Set after clear so an event in the same cycle is kept
      if (wr_hi && wr_known)
        wrote_pend <= 1'b1;
      if (cmd_take && rx_shift == stwcs_pkg::CMD_COMMIT)
        commit_pend <= 1'b1;
      if (wr_hi && cmd == stwcs_pkg::CMD_SELECT)
        select_pend <= 1'b1;
    end
  end

  // Busy window during which every address is left unacknowledged
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eeprom_store_start <= 1'b0;
      eeprom_busy <= 1'b0;
      store_cnt <= '0;
    end else begin
      eeprom_store_start <= store_req && !eeprom_busy;
      if (store_req && !eeprom_busy) begin
        eeprom_busy <= 1'b1;
        store_cnt <= STORE_LAST;
      end else if (eeprom_busy && store_cnt == '0) begin
        eeprom_busy <= 1'b0;
      end else if (eeprom_busy) begin
        store_cnt <= store_cnt - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking a_clk @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_busy_nack: assert property (
    (state == stwcs_pkg::ST_ADDR && byte_end && eeprom_busy)
      |=> !sda_oe && state == stwcs_pkg::ST_IDLE)
    else $error("address acknowledged during store");

  a_addr_ack: assert property (
    addr_take |=> sda_oe && state == stwcs_pkg::ST_ACK)
    else $error("matching address not acknowledged");

  a_auto_store: assert property (
    (frame_end && wrote_pend && !wc_set && !eeprom_busy)
      |=> eeprom_store_start ##1 eeprom_busy)
    else $error("store missing after write");

  a_wc_hold_off: assert property (
    (frame_end && wc_set && !commit_pend && !select_pend)
      |=> !eeprom_store_start)
    else $error("store started without commit");

  a_select_store: assert property (
    (frame_end && select_pend && !eeprom_busy) |=> eeprom_store_start)
    else $error("select write did not store");

  a_busy_len: assert property (
    $rose(eeprom_busy) |-> eeprom_busy[*8])
    else $error("store window too short");

  a_sda_scl_low: assert property (
    ($changed(sda_oe) && !$past(frame_end)) |-> !scl_q)
    else $error("SDA changed while SCL high");

  a_ack_hold: assert property (
    (state == stwcs_pkg::ST_ACK) |-> sda_oe)
    else $error("acknowledge released early");

  a_start_addr: assert property (
    start_evt |=> state == stwcs_pkg::ST_ADDR && bit_cnt == 4'h0)
    else $error("START not recognised");

  a_master_nack: assert property (
    (state == stwcs_pkg::ST_TXACK && bit_evt && link_bit && !frame_end)
      |=> !sda_oe && state == stwcs_pkg::ST_IDLE)
    else $error("SDA not released after master not-ack");

  a_offset_pad: assert property (
    (tx_load && cmd == stwcs_pkg::CMD_OFFSET && byte_idx == 2'h0)
      |=> tx_byte[7:5] == 3'h7)
    else $error("offset pad bits not one");

endmodule : stwcs_slave

/* File: core/stwcs_pkg.sv */
// Constants and types shared by the two-wire command slave
package stwcs_pkg;

  // ---------------------------------------------------------------
  // Clock rate and store timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  // Longest time that one nonvolatile store may take, in microseconds
  localparam int STORE_TIME_US = 10000;
  // Store busy window in reference clock cycles
  localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Command codes (the byte that follows a write address)
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_DIVIDER = 8'h01;
  localparam logic [7:0] CMD_MUX = 8'h02;
  localparam logic [7:0] CMD_DAC = 8'h08;
  localparam logic [7:0] CMD_SELECT = 8'h0D;
  localparam logic [7:0] CMD_OFFSET = 8'h0E;
  localparam logic [7:0] CMD_RANGE = 8'h37;
  localparam logic [7:0] CMD_COMMIT = 8'h3F;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int SEL_WC_BIT = 3;
  localparam logic [9:0] DIVIDER_RESET = 10'h000;
  localparam logic [9:0] MUX_RESET = 10'h060;
  localparam logic [4:0] SELECT_RESET = 5'h00;
  localparam logic [2:0] OFFSET_PAD = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] LAST_INDEX = 2'h2;

  // ---------------------------------------------------------------
  // Protocol engine states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_TXACK = 6'h20
  } stwcs_state_type;

endpackage : stwcs_pkg

/* File: sim/stwcs_master.sv */
// Two-wire bus master model that drives the slave's link pins
`timescale 1ns/10ps

module stwcs_master (
  // Bus lines (sda_pull high pulls SDA low, open drain)
  output logic link_scl,
  output logic sda_pull,
  input wire logic sda
);
  // Quarter bit; an odd figure keeps SCL unrelated to ref_clk phase.
  // The bench raises it to run the slower fast-mode bus rate
  time qtr = 103;

  // SCL stands high outside frames, SDA released to its pull-up
  initial begin
    link_scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ---------------------------------------------------------------
  // Bus conditions and bits
  // ---------------------------------------------------------------
  // A first START waits for an idle bus; a repeated one keeps the bus
  task automatic start(input bit rep);
    if (!rep) wait (link_scl && sda === 1'b1);
    sda_pull = 1'b0;
    #qtr link_scl = 1'b1;
    #qtr sda_pull = 1'b1;
    #qtr link_scl = 1'b0;
    #qtr;
  endtask : start

  task automatic stop();
    sda_pull = 1'b1;
    #qtr link_scl = 1'b1;
    #qtr sda_pull = 1'b0;
    #qtr;
  endtask : stop

  // Data moves only while SCL is low; sampled in mid-high
  task automatic one_bit(input logic b, output logic r);
    sda_pull = ~b;
    #qtr link_scl = 1'b1;
    #qtr r = sda;
    #qtr link_scl = 1'b0;
    #qtr;
  endtask : one_bit

  // Ack is high when the slave held SDA low on the ninth clock
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], r);
    end
    one_bit(1'b1, r);
    ack = ~r;
  endtask : put_byte

  // The last byte read is left without acknowledge
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, d[i]);
    end
    one_bit(last, r);
  endtask : get_byte
endmodule : stwcs_master

/* File: sim/synth_two_wire_cmd_slave_test.sv */
// Self-checking bench for the two-wire command slave
`timescale 1ns/10ps

`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); \
    end \
  end

module synth_two_wire_cmd_slave_test;
  // Arbitrary device-type code, handed to the slave as well
  localparam logic [3:0] DEV_TYPE = 4'h5;
  // Short store window keeps the run brief
  localparam int STORE_N = 2000;

  logic ref_clk, rstn, link_scl, sda_pull, sda_oe, sda_out;
  logic [13:0] range_value;
  logic [9:0] divider_word, output_mux_word, frequency_dac_word, v, port;
  logic [4:0] frequency_offset, device_select_control;
  logic eeprom_store_start, eeprom_busy, s, a;
  logic [2:0] sel;
  logic [7:0] b;
  logic [15:0] r;
  logic [7:0] cmds [3];
  int compares = 0;
  int miscompares = 0;
  int n_store = 0;
  wire sda;

  // Open-drain SDA with pull-up
  assign sda = ((sda_oe && !sda_out) || sda_pull) ? 1'b0 : 1'b1;

  // Count store pulses mid-cycle, where the flop output has settled
  always @(negedge ref_clk) begin
    if (eeprom_store_start === 1'b1) n_store++;
  end

  stwcs_slave #(
    .DEVICE_TYPE(DEV_TYPE),
    .STORE_CYCLES(STORE_N)
  ) u_stwcs_slave (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .link_scl(link_scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .range_value(range_value),
    .divider_word(divider_word),
    .output_mux_word(output_mux_word),
    .frequency_dac_word(frequency_dac_word),
    .frequency_offset(frequency_offset),
    .device_select_control(device_select_control),
    .eeprom_store_start(eeprom_store_start),
    .eeprom_busy(eeprom_busy)
  );

  stwcs_master u_stwcs_master (
    .link_scl(link_scl),
    .sda_pull(sda_pull),
    .sda(sda)
  );

  // ---------------------------------------------------------------
  // Expectations and bus transfers
  // ---------------------------------------------------------------
  function automatic logic [7:0] adr(input logic [2:0] sb, input logic rd);
    return {DEV_TYPE, sb, rd};
  endfunction : adr

  // Ten-bit register image, left-justified in two bytes
  function automatic logic [15:0] img10(input logic [9:0] x);
    return {x, 6'h00};
  endfunction : img10

  task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
    logic k;
    u_stwcs_master.start(1'b0);
    u_stwcs_master.put_byte(adr(sel, 1'b0), k);
    `CHK(k, 1'b1)
    u_stwcs_master.put_byte(cmd, k);
    `CHK(k, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_stwcs_master.put_byte(d[15 - 8 * i -: 8], k);
      `CHK(k, 1'b1)
    end
    u_stwcs_master.stop();
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
    logic k;
    d = 16'h0000;
    u_stwcs_master.start(1'b0);
    u_stwcs_master.put_byte(adr(sel, 1'b0), k);
    u_stwcs_master.put_byte(cmd, k);
    u_stwcs_master.start(1'b1);
    u_stwcs_master.put_byte(adr(sel, 1'b1), k);
    `CHK(k, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_stwcs_master.get_byte(i == n - 1, d[15 - 8 * i -: 8]);
    end
    u_stwcs_master.stop();
  endtask : rd

  task automatic probe(input logic [2:0] sb, output logic k);
    u_stwcs_master.start(1'b0);
    u_stwcs_master.put_byte(adr(sb, 1'b0), k);
    u_stwcs_master.stop();
  endtask : probe

  // The pulse is one cycle wide, so watch the busy level instead
  task automatic store_seen(output logic f);
    f = 1'b0;
    repeat (40) begin
      @(negedge ref_clk);
      if (eeprom_busy === 1'b1) f = 1'b1;
    end
  endtask : store_seen

  // A running store refuses the bus; retry once it has finished
  task automatic busy_probe();
    logic k;
    probe(sel, k);
    `CHK(k, 1'b0)
    for (int i = 0; i < 3000 && eeprom_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
    end
    probe(sel, k);
    `CHK(k, 1'b1)
  endtask : busy_probe

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Watchdog sized well above the expected run
  initial begin
    #900000;
    miscompares++;
    results();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    range_value = 14'h0000;
    sel = 3'h0;
    cmds = '{stwcs_pkg::CMD_DIVIDER, stwcs_pkg::CMD_MUX, stwcs_pkg::CMD_DAC};
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    void'($urandom(88));
    range_value = 14'($urandom);
    repeat (5) @(posedge ref_clk);
    `CHK(divider_word, stwcs_pkg::DIVIDER_RESET)
    `CHK(output_mux_word, stwcs_pkg::MUX_RESET)
    `CHK(device_select_control, stwcs_pkg::SELECT_RESET)
    `CHK(sda_out, 1'b0)
    probe(3'h3, a);
    `CHK(a, 1'b0)
    // Ten-bit registers, random junk in the spare bits
    for (int k = 0; k < 3; k++) begin
      v = 10'($urandom);
      wr(cmds[k], 2, {v, 6'($urandom)});
      port = (k == 0) ? divider_word :
             (k == 1) ? output_mux_word : frequency_dac_word;
      `CHK(port, v)
      store_seen(s);
      `CHK(s, 1'b1)
      busy_probe();
      rd(cmds[k], 2, r);
      `CHK(r, img10(v))
    end
    b = 8'($urandom);
    wr(stwcs_pkg::CMD_OFFSET, 1, {b, 8'h00});
    `CHK(frequency_offset, b[4:0])
    busy_probe();
    rd(stwcs_pkg::CMD_OFFSET, 1, r);
    `CHK(r[15:8], {3'h7, b[4:0]})
    rd(stwcs_pkg::CMD_RANGE, 2, r);
    `CHK(r, {range_value[13:1], 3'h0})
    // New select bits with write-control set still store at once
    b = {3'h5, 1'b1, 1'b1, 3'($urandom % 7 + 1)};
    wr(stwcs_pkg::CMD_SELECT, 1, {b, 8'h00});
    store_seen(s);
    `CHK(s, 1'b1)
    sel = b[2:0];
    busy_probe();
    probe(3'h0, a);
    `CHK(a, 1'b0)
    rd(stwcs_pkg::CMD_SELECT, 1, r);
    `CHK(r[15:8], {3'h0, b[4:0]})
    `CHK(device_select_control, b[4:0])
    // Write-control set: only the commit command or a select write stores
    v = 10'($urandom);
    wr(stwcs_pkg::CMD_DAC, 2, img10(v));
    `CHK(frequency_dac_word, v)
    store_seen(s);
    `CHK(s, 1'b0)
    wr(stwcs_pkg::CMD_COMMIT, 0, 16'h0000);
    store_seen(s);
    `CHK(s, 1'b1)
    busy_probe();
    // Same read at the fast-mode bus rate of 400 kHz
    u_stwcs_master.qtr = 625;
    rd(stwcs_pkg::CMD_DAC, 2, r);
    `CHK(r, img10(v))
    // Three auto stores, offset, select and commit
    `CHK(n_store, 6)
    results();
  end
endmodule : synth_two_wire_cmd_slave_test
